// File: logic/osc_ctrl_pkg.sv
// Purpose: Constants for the oscillator selection control block
// Assumes: Byte-wide peripheral access
// Notes:   Offsets, bit positions and reset values
`default_nettype none
package osc_ctrl_pkg;
    localparam logic [7:0] PERIPH_NUM      = 8'h04;
    localparam logic [7:0] GEN_CTRL_OFS    = 8'h00;
    localparam logic [7:0] ONCHIP_CTRL_OFS = 8'h01;
    localparam logic [7:0] XTAL_CTRL_OFS   = 8'h02;
    localparam int         GEN_SEL_BIT     = 0;
    localparam int         GEN_TRST_BIT    = 1;
    localparam int         ONCHIP_EN_BIT   = 0;
    localparam int         ONCHIP_SLOW_BIT = 1;
    localparam int         XTAL_EN_BIT     = 0;
    localparam int         XTAL_BIAS_BIT   = 1;
    localparam logic       GEN_TRST_RST    = 1'b0;
    localparam logic       ONCHIP_EN_RST   = 1'b1;
    localparam logic       ONCHIP_SLOW_RST = 1'b0;
    localparam logic       XTAL_EN_RST     = 1'b1;
    localparam logic       XTAL_BIAS_RST   = 1'b1;
    localparam logic       SEL_XTAL        = 1'b0;
    localparam logic [3:0] TILE_RST_CYCLES = 4'h8;
    localparam logic [3:0] TRST_CNT_IDLE   = 4'h0;
    localparam logic [7:0] RDATA_RST       = 8'h00;
    localparam logic       ACK_RST         = 1'b0;
    localparam logic [5:0] RSVD_ZERO       = 6'h00;
endpackage
`default_nettype wire

// File: logic/oscillator_select_control.sv
// Contract
// - Peripheral 4, byte-wide reads and writes only
// - General bit 0 selects source, strap reset
// - Bit 1 set: source change resets tile
// - On-chip bit 1 picks fast or slow
// - On-chip bit 0 enables oscillator, resets one
// - Crystal bit 1 enables bias, resets one
// - Crystal bit 0 enables oscillator, resets one
// Purpose: Register file and controls for the clock source selection
// Assumes: Strap pin asynchronous, peripheral port on sys_clk
// Notes:   Read data registered, one cycle after request
`timescale 1ns/1ps
`default_nettype none
module oscillator_select_control
    import osc_ctrl_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       sel_strap,
    input  wire logic       periph_sel,
    input  wire logic [7:0] periph_num,
    input  wire logic [7:0] periph_addr,
    input  wire logic       periph_wr,
    input  wire logic       periph_rd,
    input  wire logic [7:0] periph_wdata,
    output logic      [7:0] periph_rdata,
    output logic            periph_ack,
    output logic            use_onchip_osc,
    output logic            onchip_osc_en,
    output logic            onchip_osc_slow,
    output logic            xtal_osc_en,
    output logic            xtal_bias_en,
    output logic            tile_rst
);
    logic       strap_meta_r;
    logic       strap_sync_r;
    logic       strap_done_r;
    logic       sel_r;
    logic       trst_r;
    logic       slow_r;
    logic       oen_r;
    logic       xen_r;
    logic       bias_r;
    logic [3:0] trst_cnt_r;
    logic [3:0] trst_cnt_nxt;
    logic [7:0] rdata_nxt;
    logic       ack_nxt;
    logic       hit;
    logic       wr_hit;
    logic       rd_hit;
    logic       wr_gen;
    logic       wr_onchip;
    logic       wr_xtal;
    logic       sel_change;

    // Byte image of a register: only bits 1:0 are stored
    function automatic logic [7:0] reg_image(
        input logic hi_bit,
        input logic lo_bit
    );
        return {RSVD_ZERO, hi_bit, lo_bit};
    endfunction

    // Offset compare, shared by the write strobes
    function automatic logic ofs_is(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return (addr == ofs);
    endfunction

    assign hit        = periph_sel && (periph_num == PERIPH_NUM);
    assign wr_hit     = hit && periph_wr;
    assign rd_hit     = hit && periph_rd;
    assign wr_gen     = wr_hit && ofs_is(periph_addr, GEN_CTRL_OFS);
    assign wr_onchip  = wr_hit && ofs_is(periph_addr, ONCHIP_CTRL_OFS);
    assign wr_xtal    = wr_hit && ofs_is(periph_addr, XTAL_CTRL_OFS);
    assign sel_change = wr_gen && strap_done_r && (periph_wdata[GEN_SEL_BIT] != sel_r);

    // Strap synchroniser; runs in reset so the strap is settled at release
    always_ff @(posedge sys_clk)
    begin
        strap_meta_r <= sel_strap;
        strap_sync_r <= strap_meta_r;
    end

    // Source select, caught from the strap at the first edge after release
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_done_r <= 1'b0;
            sel_r        <= SEL_XTAL;
        end
        else if (!strap_done_r)
        begin
            strap_done_r <= 1'b1;
            sel_r        <= strap_sync_r;
        end
        else if (wr_gen)
        begin
            sel_r <= periph_wdata[GEN_SEL_BIT];
        end
    end

    // Tile reset enable
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trst_r <= GEN_TRST_RST;
        end
        else if (wr_gen)
        begin
            trst_r <= periph_wdata[GEN_TRST_BIT];
        end
    end

    // On-chip oscillator speed and enable
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slow_r <= ONCHIP_SLOW_RST;
            oen_r  <= ONCHIP_EN_RST;
        end
        else if (wr_onchip)
        begin
            slow_r <= periph_wdata[ONCHIP_SLOW_BIT];
            oen_r  <= periph_wdata[ONCHIP_EN_BIT];
        end
    end

    // Crystal oscillator bias and enable
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bias_r <= XTAL_BIAS_RST;
            xen_r  <= XTAL_EN_RST;
        end
        else if (wr_xtal)
        begin
            bias_r <= periph_wdata[XTAL_BIAS_BIT];
            xen_r  <= periph_wdata[XTAL_EN_BIT];
        end
    end

    // Tile reset length counter, reloaded by each qualifying write
    always_comb
    begin
        trst_cnt_nxt = trst_cnt_r;
        if (trst_r && sel_change)
        begin
            trst_cnt_nxt = TILE_RST_CYCLES;
        end
        else if (trst_cnt_r != TRST_CNT_IDLE)
        begin
            trst_cnt_nxt = trst_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trst_cnt_r <= TRST_CNT_IDLE;
        end
        else
        begin
            trst_cnt_r <= trst_cnt_nxt;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        rdata_nxt = periph_rdata;
        if (rd_hit)
        begin
            case (periph_addr)
                GEN_CTRL_OFS:    rdata_nxt = reg_image(trst_r, sel_r);
                ONCHIP_CTRL_OFS: rdata_nxt = reg_image(slow_r, oen_r);
                XTAL_CTRL_OFS:   rdata_nxt = reg_image(bias_r, xen_r);
                default:         rdata_nxt = RDATA_RST;
            endcase
        end
    end

    // Every accepted byte access is answered one cycle later
    assign ack_nxt = wr_hit || rd_hit;

    // Read data holds until the next read
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periph_rdata <= RDATA_RST;
        end
        else
        begin
            periph_rdata <= rdata_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periph_ack <= ACK_RST;
        end
        else
        begin
            periph_ack <= ack_nxt;
        end
    end

    // Oscillator controls straight from the stored bits
    assign use_onchip_osc  = sel_r;
    assign onchip_osc_en   = oen_r;
    assign onchip_osc_slow = slow_r;
    assign xtal_osc_en     = xen_r;
    assign xtal_bias_en    = bias_r;
    assign tile_rst        = (trst_cnt_r != TRST_CNT_IDLE);
endmodule
`default_nettype wire

// File: sim/osc_sel_sva.sv
// Purpose: Port checks for the oscillator select control
// Assumes: One clock, async reset
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module osc_sel_sva (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       periph_sel,
    input wire logic       periph_wr,
    input wire logic       periph_rd,
    input wire logic       periph_ack,
    input wire logic       use_onchip_osc,
    input wire logic       onchip_osc_en,
    input wire logic       onchip_osc_slow,
    input wire logic       tile_rst,
    input wire logic       xtal_osc_en,
    input wire logic       xtal_bias_en,
    input wire logic [7:0] periph_num,
    input wire logic [7:0] periph_addr,
    input wire logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire       hit = periph_sel && periph_num == 8'h04 && (periph_wr || periph_rd);
    wire [7:0] wa  = hit && periph_wr ? periph_addr : 8'hff;
    property p_ack; periph_ack == $past(hit); endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_sel; wa == 8'h00 |=> use_onchip_osc == $past(periph_wdata[0]); endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_trs; $rose(tile_rst) |-> $changed(use_onchip_osc) ##0 tile_rst[*8]; endproperty
    a_trs: assert property (p_trs) else $error("trs");
    property p_slw; wa == 8'h01 |=> onchip_osc_slow == $past(periph_wdata[1]); endproperty
    a_slw: assert property (p_slw) else $error("slw");
    property p_oen; wa == 8'h01 |=> onchip_osc_en == $past(periph_wdata[0]); endproperty
    a_oen: assert property (p_oen) else $error("oen");
    property p_bia; wa == 8'h02 |=> xtal_bias_en == $past(periph_wdata[1]); endproperty
    a_bia: assert property (p_bia) else $error("bia");
    property p_xen; wa == 8'h02 |=> xtal_osc_en == $past(periph_wdata[0]); endproperty
    a_xen: assert property (p_xen) else $error("xen");
    property p_rsv; $past(hit && periph_rd) |-> periph_rdata[7:2] == 6'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("rsv");
    cover property (tile_rst);
    cover property (wa == 8'h02);
    cover property (hit && periph_rd);
endmodule
bind oscillator_select_control osc_sel_sva u_sva (.*);
`default_nettype wire

// File: sim/oscillator_select_control_tb.sv
// Purpose: Bench for the oscillator select control
// Assumes: Strap high
// Notes:   Reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
module oscillator_select_control_tb;
    logic        sys_clk = 1'b0, sys_rst, sel_strap, periph_sel, periph_wr, periph_rd;
    logic        periph_ack, use_onchip_osc, onchip_osc_en, onchip_osc_slow, tile_rst;
    logic        xtal_osc_en, xtal_bias_en;
    logic [7:0]  periph_num, periph_addr, periph_wdata, periph_rdata, d;
    logic [31:0] r = 32'he524;
    logic [8:0]  q[$];
    int          n_mismatch = 0, n_compared = 0, n_t = 0;
    oscillator_select_control u_dut (.*);
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic ok);
        n_compared++;
        n_mismatch += ok !== 1'b1;
        if (ok !== 1'b1) $display("[ERR] %0t mismatch", $time);
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v, x = 8'h00);
        {periph_sel, periph_wr, periph_rd, periph_num, periph_addr, periph_wdata} <= {1'b1, w, !w, a, v};
        if (a[15:8] == 8'h04) q.push_back({!w, x});
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk)
    begin
        n_t <= n_t + (tile_rst === 1'b1);
        if (periph_ack === 1'b1)
        begin
            chk(q.size() > 0 && (!q[0][8] || periph_rdata === q[0][7:0]));
            void'(q.pop_front());
        end
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        {sys_rst, sel_strap, periph_sel, periph_wr, periph_rd} <= 5'h18;
        {periph_num, periph_addr, periph_wdata} <= 24'h04_0000;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({use_onchip_osc, onchip_osc_en, onchip_osc_slow, xtal_osc_en, xtal_bias_en, tile_rst} === 6'h36);
        acc(1, 16'h0500, 8'h00);
        for (int i = 0; i < 4; i++)
            acc(0, 16'h0400 + 16'(i), 8'h00, 8'(i == 2 ? 3 : i < 2));
        for (int i = 0; i < 8; i++)
        begin
            r = xs(r);
            d = r[7:0] | {6'h00, r[8], !r[8]};
            acc(1, 16'h0401 + r[8], d);
            acc(0, 16'h0401 + r[8], 8'h00, d & 8'h03);
            chk((r[8] ? {xtal_bias_en, xtal_osc_en} : {onchip_osc_slow, onchip_osc_en}) === d[1:0]);
        end
        acc(1, 16'h0402, 8'h03);
        for (int i = 0; i < 4; i++)
            acc(1, 16'h0400, 8'(32'h0100_0203 >> 8 * i));
        acc(0, 16'h0400, 8'h00, 8'h01);
        chk(use_onchip_osc === 1'b1);
        periph_sel <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk(n_t == 8 && q.size() == 0);
        results();
    end
endmodule
`default_nettype wire
